/* opra_pkg.sv */
// constants shared by both ends of the protection register link
package opra_pkg;
  localparam int PART_W = 3;
  localparam int OFF_W = 8;
  localparam int DW = 16;
  localparam int ID_WORDS = 9;
  localparam logic [PART_W-1:0] PARAM_PART = 3'h0;
  // command codes on the link
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_PROT_PROG = 8'hc0;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  // identifier-space offsets of the identification register
  localparam logic [OFF_W-1:0] ID_LOCK_OFF = 8'h80;
  localparam logic [OFF_W-1:0] ID_FACT_OFF = 8'h81;
  localparam logic [OFF_W-1:0] ID_USER_OFF = 8'h85;
  localparam logic [OFF_W-1:0] ID_LAST_OFF = 8'h88;
  // segment_lock_word
  localparam logic [DW-1:0] LOCK_RESET = 16'hfffe;
  localparam logic [DW-1:0] USER_LOCK_VALUE = 16'hfffd;
  localparam int FACTORY_SEGMENT_LOCK_BIT = 0;
  localparam int USER_SEGMENT_LOCK_BIT = 1;
  localparam logic [DW-1:0] ERASED_WORD = 16'hffff;
  // arbitrary neutral factory number
  localparam logic [63:0] FACTORY_UID = 64'h0123_4567_89ab_cdef;
  // status_flags
  localparam int SR_READY = 7;
  localparam int SR_SEQ_ERR = 5;
  localparam int SR_PROG_ERR = 4;
  localparam int SR_VPP_ERR = 3;
  localparam logic [7:0] SR_RESET = 8'h80;
  // program time
  localparam int CLK_PERIOD_NS = 40;
  localparam int PROG_TIME_NS = 10000;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 9;
  // host apb registers
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WDATA = 8'h04;
  localparam logic [7:0] REG_RDATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam logic [7:0] REG_IRQ_ST = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK = 8'h14;
  localparam int CTRL_PART_LSB = 8;
  localparam int CTRL_OFF_LSB = 16;
  localparam int RDATA_ERR_BIT = 16;
  localparam int STAT_FLAGS_LSB = 8;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
endpackage : opra_pkg

/* opra_if.sv */
// command link between host end and device end
`timescale 1ns/100ps
`default_nettype none
interface opra_if;
  import opra_pkg::*;
  logic req_valid;
  logic req_ready;
  logic [7:0] req_code;
  logic [PART_W-1:0] req_part;
  logic [OFF_W-1:0] req_off;
  logic [DW-1:0] req_data;
  logic rsp_valid;
  logic rsp_err;
  logic [DW-1:0] rsp_data;
  logic [7:0] status;
  modport dev (
    input req_valid, req_code, req_part, req_off, req_data,
    output req_ready, rsp_valid, rsp_err, rsp_data, status
  );
  modport host (
    output req_valid, req_code, req_part, req_off, req_data,
    input req_ready, rsp_valid, rsp_err, rsp_data, status
  );
endinterface : opra_if
`default_nettype wire

/* opra_device.sv */
// device end: identification register read, program and lock logic
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Function
// RULE1: hold 128-bit identification register apart from array
// RULE2: lower 64 bits factory number, not alterable
// RULE3: upper 64 bits user segment, lockable
// RULE4: user bits programmable individually, repeatedly
// RULE5: locked user segment refuses all programming
// RULE6: concurrency with register only against main partitions
// RULE7: main busy: register read elsewhere, not parameter
// RULE8: register read avoids busy and parameter partition
// RULE9: programming register puts parameter partition in status
// RULE10: parameter partition busy: no register reads anywhere
// RULE11: identifier mode returns register 16 bits per read
// RULE12: array-read command leaves identifier mode
// RULE13: program only at parameter partition, 16-bit words
// RULE14: program outside register space sets status bit 4
// RULE15: factory lock bit cleared, factory segment locked
// RULE16: host locks user segment writing FFFDh
// RULE17: program into locked segment sets bits 4, 5
// RULE18: low program supply rejects program, sets bit 3
// RULE19: programming only clears bits, never sets them
module opra_device (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // command link
  opra_if.dev LINK,
  // program supply below program_supply_lockout_level, asynchronous pin
  input wire logic VPP_LOW,
  // array operations outside this block
  input wire logic MAIN_BUSY,
  input wire logic [opra_pkg::PART_W-1:0] MAIN_BUSY_PART,
  input wire logic PARAM_BUSY,
  // array read path
  output logic [opra_pkg::PART_W+opra_pkg::OFF_W-1:0] ARRAY_ADDR,
  input wire logic [opra_pkg::DW-1:0] ARRAY_DATA
);
  import opra_pkg::*;

  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_PROG = 2'b10
  } opra_state_e;

  typedef struct packed {
    opra_state_e state;
    logic vpp_s1;
    logic vpp_s2;
    logic [(1 << PART_W)-1:0] id_mode;
    logic [7:0] status;
    logic [ID_WORDS-1:0][DW-1:0] words;
    logic [3:0] tgt;
    logic [DW-1:0] pdata;
    logic [CNT_W-1:0] cnt;
    logic arr_pend;
    logic [PART_W+OFF_W-1:0] arr_addr;
    logic rsp_valid;
    logic rsp_err;
    logic [DW-1:0] rsp_data;
  } opra_dev_s;

  opra_dev_s r_reg;
  opra_dev_s r_next;
  logic accept;
  logic [3:0] idx;
  logic id_blocked;

  function automatic logic id_hit(input logic [OFF_W-1:0] off);
    id_hit = (off >= ID_LOCK_OFF) && (off <= ID_LAST_OFF);
  endfunction : id_hit

  function automatic logic [3:0] id_idx(input logic [OFF_W-1:0] off);
    logic [OFF_W-1:0] d;
    d = off - ID_LOCK_OFF;
    id_idx = d[3:0];
  endfunction : id_idx

  // lock word, factory number, erased user segment
  localparam logic [ID_WORDS-1:0][DW-1:0] WORDS_RESET =
    {{4{ERASED_WORD}}, FACTORY_UID, LOCK_RESET}; // [RULE1] [RULE2] [RULE15]

  localparam opra_dev_s DEV_RESET = '{
    state: S_IDLE,
    vpp_s1: 1'b0,
    vpp_s2: 1'b0,
    id_mode: '0,
    status: SR_RESET,
    words: WORDS_RESET,
    tgt: 4'h0,
    pdata: ERASED_WORD,
    cnt: '0,
    arr_pend: 1'b0,
    arr_addr: '0,
    rsp_valid: 1'b0,
    rsp_err: 1'b0,
    rsp_data: '0
  };

  // a program request waits while another program runs
  assign LINK.req_ready = !r_reg.arr_pend &&
    !(r_reg.state == S_PROG && LINK.req_code == CMD_PROT_PROG);
  assign accept = LINK.req_valid && LINK.req_ready;
  assign idx = id_idx(LINK.req_off);
  // register reads refused while the shared resources are in use
  assign id_blocked = PARAM_BUSY || // [RULE10]
    (r_reg.state == S_PROG) || // [RULE9]
    (MAIN_BUSY && (LINK.req_part == MAIN_BUSY_PART || LINK.req_part == PARAM_PART)); // [RULE6] [RULE7] [RULE8]

  assign LINK.rsp_valid = r_reg.rsp_valid;
  assign LINK.rsp_err = r_reg.rsp_err;
  assign LINK.rsp_data = r_reg.rsp_data;
  assign LINK.status = r_reg.status;
  assign ARRAY_ADDR = r_reg.arr_addr;

  always_comb
  begin
    r_next = r_reg;
    r_next.rsp_valid = 1'b0;
    r_next.rsp_err = 1'b0;
    r_next.vpp_s1 = VPP_LOW;
    r_next.vpp_s2 = r_reg.vpp_s1;
    if (r_reg.arr_pend)
    begin
      r_next.arr_pend = 1'b0;
      r_next.rsp_valid = 1'b1;
      r_next.rsp_data = ARRAY_DATA;
    end
    case (r_reg.state)
      S_IDLE:
      begin
      end
      S_PROG:
      begin
        if (r_reg.cnt == '0)
        begin
          r_next.words[r_reg.tgt] = r_reg.words[r_reg.tgt] & r_reg.pdata; // [RULE4] [RULE19]
          r_next.status[SR_READY] = 1'b1;
          r_next.state = S_IDLE;
        end
        else
        begin
          r_next.cnt = r_reg.cnt - 1'b1;
        end
      end
      default:
      begin
        r_next.state = S_IDLE;
      end
    endcase
    if (accept)
    begin
      r_next.rsp_valid = 1'b1;
      case (LINK.req_code)
        CMD_READ_ID:
        begin
          r_next.id_mode[LINK.req_part] = 1'b1;
        end
        CMD_READ_ARRAY:
        begin
          r_next.id_mode[LINK.req_part] = 1'b0; // [RULE12]
        end
        CMD_READ_STATUS:
        begin
          r_next.rsp_data = {8'h00, r_reg.status};
        end
        CMD_CLEAR_STATUS:
        begin
          r_next.status[SR_SEQ_ERR] = 1'b0;
          r_next.status[SR_PROG_ERR] = 1'b0;
          r_next.status[SR_VPP_ERR] = 1'b0;
        end
        CMD_READ:
        begin
          if (r_reg.state == S_PROG && LINK.req_part == PARAM_PART)
          begin
            r_next.rsp_data = {8'h00, r_reg.status}; // [RULE9]
          end
          else if (r_reg.id_mode[LINK.req_part])
          begin
            // array data is not readable through an identifier-mode partition: offsets outside the register read zero
            if (!id_hit(LINK.req_off))
            begin
              r_next.rsp_data = '0;
            end
            else if (id_blocked)
            begin
              r_next.rsp_err = 1'b1; // [RULE7] [RULE10]
              r_next.rsp_data = ERASED_WORD;
            end
            else
            begin
              r_next.rsp_data = r_reg.words[idx]; // [RULE11]
            end
          end
          else
          begin
            // array word arrives on the following cycle
            r_next.rsp_valid = 1'b0;
            r_next.arr_pend = 1'b1;
            r_next.arr_addr = {LINK.req_part, LINK.req_off};
          end
        end
        CMD_PROT_PROG:
        begin
          if (r_reg.vpp_s2)
          begin
            r_next.rsp_err = 1'b1;
            r_next.status[SR_VPP_ERR] = 1'b1; // [RULE18]
          end
          else if (LINK.req_part != PARAM_PART || !id_hit(LINK.req_off) || PARAM_BUSY)
          begin
            r_next.rsp_err = 1'b1;
            r_next.status[SR_PROG_ERR] = 1'b1; // [RULE13] [RULE14]
          end
          else if ((LINK.req_off >= ID_USER_OFF &&
                    !r_reg.words[0][USER_SEGMENT_LOCK_BIT]) || // [RULE3] [RULE5]
                   (LINK.req_off >= ID_FACT_OFF && LINK.req_off < ID_USER_OFF &&
                    !r_reg.words[0][FACTORY_SEGMENT_LOCK_BIT])) // [RULE2] [RULE15]
          begin
            r_next.rsp_err = 1'b1;
            r_next.status[SR_PROG_ERR] = 1'b1; // [RULE17]
            r_next.status[SR_SEQ_ERR] = 1'b1; // [RULE17]
          end
          else
          begin
            // lock word is accepted like any word, so FFFDh locks the user segment
            r_next.state = S_PROG; // [RULE13] [RULE16]
            r_next.status[SR_READY] = 1'b0;
            r_next.tgt = idx;
            r_next.pdata = LINK.req_data;
            r_next.cnt = CNT_W'(PROG_CYCLES - 1);
          end
        end
        default:
        begin
          r_next.rsp_err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      r_reg <= DEV_RESET;
    end
    else
    begin
      r_reg <= r_next;
    end
  end
endmodule : opra_device
`default_nettype wire

/* opra_host.sv */
// host end: apb registers that issue link commands and raise interrupts
`timescale 1ns/100ps
`default_nettype none
module opra_host (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // interrupt
  output logic IRQ,
  // command link
  opra_if.host LINK
);
  import opra_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_REQ = 3'b010,
    H_RSP = 3'b100
  } opra_hstate_e;

  typedef struct packed {
    opra_hstate_e state;
    logic [7:0] code;
    logic [PART_W-1:0] part;
    logic [OFF_W-1:0] off;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    logic rerr;
    logic [1:0] irq_st;
    logic [1:0] irq_mask;
    logic prog_wait;
    logic [31:0] prdata;
  } opra_host_s;

  opra_host_s r_reg;
  opra_host_s r_next;
  logic mapped;
  logic wr;
  logic [1:0] irq_set;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == REG_CTRL) || (a == REG_WDATA) || (a == REG_RDATA) ||
      (a == REG_STAT) || (a == REG_IRQ_ST) || (a == REG_IRQ_MASK);
  endfunction : is_mapped

  assign mapped = is_mapped(PADDR);
  assign wr = PSEL && PENABLE && PWRITE && mapped;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign PRDATA = r_reg.prdata;
  assign IRQ = |(r_reg.irq_st & r_reg.irq_mask);
  assign LINK.req_valid = (r_reg.state == H_REQ);
  assign LINK.req_code = r_reg.code;
  assign LINK.req_part = r_reg.part;
  assign LINK.req_off = r_reg.off;
  assign LINK.req_data = r_reg.wdata;

  always_comb
  begin
    r_next = r_reg;
    irq_set = 2'b00;
    // an accepted program reports done once the device is ready again
    if (r_reg.prog_wait && LINK.status[SR_READY])
    begin
      irq_set[IRQ_DONE] = 1'b1;
      r_next.prog_wait = 1'b0;
    end
    case (r_reg.state)
      H_IDLE:
      begin
        if (wr && PADDR == REG_CTRL)
        begin
          r_next.code = PWDATA[7:0];
          r_next.part = PWDATA[CTRL_PART_LSB +: PART_W];
          r_next.off = PWDATA[CTRL_OFF_LSB +: OFF_W];
          r_next.state = H_REQ;
        end
      end
      H_REQ:
      begin
        if (LINK.req_ready)
        begin
          r_next.state = H_RSP;
        end
      end
      H_RSP:
      begin
        if (LINK.rsp_valid)
        begin
          r_next.rdata = LINK.rsp_data;
          r_next.rerr = LINK.rsp_err;
          irq_set[IRQ_ERR] = LINK.rsp_err;
          // the host is free for reads in other partitions while the device programs
          if (r_reg.code == CMD_PROT_PROG && !LINK.rsp_err)
          begin
            r_next.prog_wait = 1'b1;
          end
          else
          begin
            irq_set[IRQ_DONE] = 1'b1;
          end
          r_next.state = H_IDLE;
        end
      end
      default:
      begin
        r_next.state = H_IDLE;
      end
    endcase
    if (wr && PADDR == REG_WDATA)
    begin
      r_next.wdata = PWDATA[DW-1:0];
    end
    if (wr && PADDR == REG_IRQ_MASK)
    begin
      r_next.irq_mask = PWDATA[1:0];
    end
    // a new event wins over a write-one clear in the same cycle
    if (wr && PADDR == REG_IRQ_ST)
    begin
      r_next.irq_st = (r_reg.irq_st & ~PWDATA[1:0]) | irq_set;
    end
    else
    begin
      r_next.irq_st = r_reg.irq_st | irq_set;
    end
    // read data captured in the setup cycle
    if (PSEL && !PENABLE && !PWRITE)
    begin
      case (PADDR)
        REG_CTRL: r_next.prdata = {8'h00, r_reg.off, 5'h00, r_reg.part, r_reg.code};
        REG_WDATA: r_next.prdata = {16'h0000, r_reg.wdata};
        REG_RDATA: r_next.prdata = {15'h0000, r_reg.rerr, r_reg.rdata};
        REG_STAT: r_next.prdata = {16'h0000, LINK.status, 7'h00, r_reg.state != H_IDLE};
        REG_IRQ_ST: r_next.prdata = {30'h0, r_reg.irq_st};
        REG_IRQ_MASK: r_next.prdata = {30'h0, r_reg.irq_mask};
        default: r_next.prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      r_reg <= '{state: H_IDLE, code: CMD_READ_ARRAY, default: '0};
    end
    else
    begin
      r_reg <= r_next;
    end
  end
endmodule : opra_host
`default_nettype wire

/* opra_pkg_end.sv */
// no declarations: the shared constants are kept in opra_pkg.sv

/* opra_checker.sv */
// assertions on the command link between the host and device ends
`timescale 1ns/100ps
`default_nettype none
module opra_checker
  import opra_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // link request
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [7:0] req_code,
  input wire logic [opra_pkg::PART_W-1:0] req_part,
  input wire logic [opra_pkg::OFF_W-1:0] req_off,
  input wire logic [opra_pkg::DW-1:0] req_data,
  // link answer
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [opra_pkg::DW-1:0] rsp_data,
  input wire logic [7:0] status
);
  logic take;
  logic prog;
  logic bad;
  assign take = req_valid && req_ready;
  assign prog = take && req_code == CMD_PROT_PROG;
  assign bad = req_part != PARAM_PART || req_off < ID_LOCK_OFF || req_off > ID_LAST_OFF;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  a_req_held: assert property (req_valid && !req_ready |=> req_valid && $stable(req_data)
    && $stable(req_code) && $stable(req_off) && $stable(req_part))
    else $error("stalled request dropped");
  a_prog_answer: assert property (prog |=> rsp_valid)
    else $error("program not answered");
  a_prog_stall: assert property (!status[SR_READY] && req_valid && req_code == CMD_PROT_PROG
    |-> !req_ready)
    else $error("program taken while programming");
  a_prog_time: assert property ($fell(status[SR_READY])
    |-> ##249 !status[SR_READY] ##1 status[SR_READY])
    else $error("program time wrong");
  a_busy_cause: assert property ($fell(status[SR_READY])
    |-> rsp_valid && !rsp_err && $past(prog))
    else $error("busy without accepted program");
  a_addr_err: assert property (prog && bad
    |=> rsp_valid && rsp_err && (status[SR_PROG_ERR] || status[SR_VPP_ERR]))
    else $error("bad program address accepted");
  a_lock_pair: assert property ($rose(status[SR_SEQ_ERR])
    |-> status[SR_PROG_ERR] && rsp_valid && rsp_err)
    else $error("lock error flags unpaired");
  a_supply_err: assert property ($rose(status[SR_VPP_ERR]) |-> rsp_valid && rsp_err)
    else $error("supply error without refusal");
  a_clear_flags: assert property (take && req_code == CMD_CLEAR_STATUS
    |=> status[SR_SEQ_ERR:SR_VPP_ERR] == 3'h0)
    else $error("error flags not cleared");
  c_prog: cover property (prog ##1 rsp_valid && !rsp_err);
  c_lock: cover property ($rose(status[SR_SEQ_ERR]));
  c_supply: cover property ($rose(status[SR_VPP_ERR]));
  c_stall: cover property (req_valid && !req_ready && req_code == CMD_PROT_PROG);
endmodule : opra_checker
`default_nettype wire

/* opra_tb_top.sv */
// self-checking bench joining the host and device ends over the link
`timescale 1ns/100ps
`default_nettype none
module opra_tb_top;
  import opra_pkg::*;
  typedef struct packed {
    logic [7:0] c;
    logic [2:0] p;
    logic [7:0] o;
    logic [15:0] d;
    logic cd;
    logic [15:0] x;
    logic [3:0] f;
  } opra_row_s;
  localparam opra_row_s ROWS [20] = '{
    '{CMD_READ_ID, 3'h1, 8'h00, 16'h0, 1'h0, 16'h0, 4'h0},
    '{CMD_READ, 3'h1, 8'h80, 16'h0, 1'h1, LOCK_RESET, 4'h0},
    '{CMD_READ, 3'h1, 8'h81, 16'h0, 1'h1, FACTORY_UID[15:0], 4'h0},
    '{CMD_READ, 3'h1, 8'h88, 16'h0, 1'h1, ERASED_WORD, 4'h0},
    '{CMD_READ, 3'h1, 8'h10, 16'h0, 1'h1, 16'h0, 4'h0},
    '{CMD_PROT_PROG, 3'h0, 8'h85, 16'hff0f, 1'h0, 16'h0, 4'h0},
    '{CMD_PROT_PROG, 3'h0, 8'h85, 16'hf0ff, 1'h0, 16'h0, 4'h0},
    '{CMD_READ, 3'h1, 8'h85, 16'h0, 1'h1, 16'hf00f, 4'h0},
    '{CMD_PROT_PROG, 3'h1, 8'h85, 16'h0, 1'h0, 16'h0, 4'ha},
    '{CMD_PROT_PROG, 3'h0, 8'h89, 16'h0, 1'h0, 16'h0, 4'ha},
    '{CMD_PROT_PROG, 3'h0, 8'h81, 16'h0, 1'h0, 16'h0, 4'he},
    '{CMD_READ, 3'h1, 8'h81, 16'h0, 1'h1, FACTORY_UID[15:0], 4'h0},
    '{CMD_PROT_PROG, 3'h0, 8'h80, USER_LOCK_VALUE, 1'h0, 16'h0, 4'h0},
    '{CMD_READ, 3'h1, 8'h80, 16'h0, 1'h1, 16'hfffc, 4'h0},
    '{CMD_PROT_PROG, 3'h0, 8'h86, 16'h0, 1'h0, 16'h0, 4'he},
    '{CMD_READ, 3'h1, 8'h86, 16'h0, 1'h1, ERASED_WORD, 4'h0},
    '{CMD_READ_ID, 3'h2, 8'h00, 16'h0, 1'h0, 16'h0, 4'h0},
    '{CMD_READ, 3'h2, 8'h85, 16'h0, 1'h1, 16'hf00f, 4'h0},
    '{CMD_READ_ARRAY, 3'h2, 8'h00, 16'h0, 1'h0, 16'h0, 4'h0},
    '{CMD_READ, 3'h2, 8'h05, 16'h0, 1'h1, 16'ha205, 4'h0}
  };
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, irq, last_err;
  logic vpp_low, main_busy, param_busy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [PART_W-1:0] busy_part;
  logic [PART_W+OFF_W-1:0] array_addr;
  logic [DW-1:0] array_data;
  int mismatches;
  int tests_run;
  // array content follows its address so array reads are predictable
  assign array_data = {5'h14, array_addr};
  opra_if u_opra_if ();
  opra_host u_opra_host (.CLK(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq), .LINK(u_opra_if));
  opra_device u_opra_device (.CLK(clk), .RESET_N(reset_n), .LINK(u_opra_if),
    .VPP_LOW(vpp_low), .MAIN_BUSY(main_busy), .MAIN_BUSY_PART(busy_part),
    .PARAM_BUSY(param_busy), .ARRAY_ADDR(array_addr), .ARRAY_DATA(array_data));
  opra_checker u_opra_checker (.CLK(clk), .RESET_N(reset_n),
    .req_valid(u_opra_if.req_valid), .req_ready(u_opra_if.req_ready),
    .req_code(u_opra_if.req_code), .req_part(u_opra_if.req_part),
    .req_off(u_opra_if.req_off), .req_data(u_opra_if.req_data),
    .rsp_valid(u_opra_if.rsp_valid), .rsp_err(u_opra_if.rsp_err),
    .rsp_data(u_opra_if.rsp_data), .status(u_opra_if.status));
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  task automatic wrap_up();
    if (mismatches == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'h1 && n < 50);
    if (n >= 50)
    begin
      mismatches++;
      wrap_up();
    end
    r = prdata;
    last_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // polls until the host is idle and, if asked, the device is ready again
  task automatic wait_idle(input logic rdy);
    int n;
    logic [31:0] r;
    for (n = 0; n < 200; n++)
    begin
      apb(1'h0, REG_STAT, 32'h0, r);
      if (r[0] === 1'h0 && (r[15] === 1'h1 || !rdy))
        break;
    end
    if (n == 200)
    begin
      mismatches++;
      wrap_up();
    end
  endtask : wait_idle
  task automatic run(input opra_row_s w);
    logic [31:0] r;
    apb(1'h1, REG_WDATA, {16'h0, w.d}, r);
    apb(1'h1, REG_CTRL, {8'h0, w.o, 5'h0, w.p, w.c}, r);
    wait_idle(1'h1);
    apb(1'h0, REG_RDATA, 32'h0, r);
    if (w.cd)
      chk("rdata", {16'h0, w.x}, {16'h0, r[15:0]});
    chk("err", {31'h0, w.f[3]}, {31'h0, r[RDATA_ERR_BIT]});
    apb(1'h0, REG_STAT, 32'h0, r);
    chk("flags", {29'h0, w.f[2:0]}, {29'h0, r[13:11]});
    if (w.f[2:0] != 3'h0)
      run('{CMD_CLEAR_STATUS, 3'h0, 8'h00, 16'h0, 1'h0, 16'h0, 4'h0});
  endtask : run
  initial
  begin
    reset_n = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    vpp_low = 1'h0;
    main_busy = 1'h0;
    busy_part = 3'h0;
    param_busy = 1'h0;
    mismatches = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    reset_n <= 1'h1;
    apb(1'h0, REG_STAT, 32'h0, v);
    chk("stat", 32'h8000, {16'h0, v[15:0]});
    foreach (ROWS[i])
      run(ROWS[i]);
    // supply below lockout, wait out the input synchroniser
    vpp_low <= 1'h1;
    repeat (3) @(posedge clk);
    run('{CMD_PROT_PROG, 3'h0, 8'h87, 16'h0, 1'h0, 16'h0, 4'h9});
    vpp_low <= 1'h0;
    param_busy <= 1'h1;
    run('{CMD_READ, 3'h1, 8'h85, 16'h0, 1'h1, 16'hffff, 4'h8});
    param_busy <= 1'h0;
    main_busy <= 1'h1;
    busy_part <= 3'h3;
    run('{CMD_READ_ID, 3'h3, 8'h00, 16'h0, 1'h0, 16'h0, 4'h0});
    run('{CMD_READ, 3'h3, 8'h85, 16'h0, 1'h1, 16'hffff, 4'h8});
    run('{CMD_READ, 3'h1, 8'h85, 16'h0, 1'h1, 16'hf00f, 4'h0});
    run('{CMD_READ_ID, 3'h0, 8'h00, 16'h0, 1'h0, 16'h0, 4'h0});
    run('{CMD_READ, 3'h0, 8'h85, 16'h0, 1'h1, 16'hffff, 4'h8});
    main_busy <= 1'h0;
    // commands land while the lock word is still programming
    for (int k = 0; k < 3; k++)
    begin
      apb(1'h1, REG_WDATA, 32'hffff, v);
      apb(1'h1, REG_CTRL, {8'h0, ID_LOCK_OFF, 8'h0, CMD_PROT_PROG}, v);
      wait_idle(1'h0);
      if (k == 0)
        run('{CMD_READ, 3'h1, 8'h85, 16'h0, 1'h1, 16'hffff, 4'h8});
      else if (k == 1)
        run('{CMD_READ, 3'h0, 8'h85, 16'h0, 1'h1, 16'h0000, 4'h0});
      else
        run('{CMD_PROT_PROG, 3'h0, 8'h80, 16'hffff, 1'h0, 16'h0, 4'h0});
    end
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'h1, REG_IRQ_MASK, 32'h3, v);
    repeat (2) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'h0, REG_IRQ_ST, 32'h0, v);
    chk("irq_st", 32'h3, v);
    apb(1'h1, REG_IRQ_ST, 32'h3, v);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'h0, 8'h40, 32'h0, v);
    chk("slverr", 32'h1, {31'h0, last_err});
    // mid-run reset returns the host registers to their reset values
    reset_n <= 1'h0;
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    reset_n <= 1'h1;
    apb(1'h0, REG_IRQ_MASK, 32'h0, v);
    chk("mask", 32'h0, v);
    apb(1'h0, REG_STAT, 32'h0, v);
    chk("stat", 32'h8000, v);
    wrap_up();
  end
endmodule : opra_tb_top
`default_nettype wire
